// File: hdl/dtc_pkg.sv
// dtc_pkg: constants shared by the diagnostic threshold checker files
// assumes: 32-bit axi4-lite data, register index times four gives the byte address
package dtc_pkg;
  // bus geometry
  localparam int DTC_ADDR_W = 12;
  localparam int DTC_IDX_W = 10;
  // register indices, byte address is four times the index
  localparam logic [9:0] DTC_IDX_ACC_LOW = 10'h042;
  localparam logic [9:0] DTC_IDX_SHORT = 10'h043;
  localparam logic [9:0] DTC_IDX_OPEN_LOW = 10'h044;
  localparam logic [9:0] DTC_IDX_OPEN_HIGH = 10'h045;
  localparam logic [9:0] DTC_IDX_CTRL = 10'h060;
  localparam logic [9:0] DTC_IDX_STATUS = 10'h061;
  localparam logic [9:0] DTC_IDX_MASK = 10'h062;
  localparam logic [9:0] DTC_IDX_FAIL_CELLS = 10'h063;
  // field layout
  localparam int DTC_ACC_W = 10;
  localparam int DTC_ACC_LSB = 6;
  localparam int DTC_BAL_W = 14;
  localparam int DTC_BAL_LSB = 2;
  localparam int DTC_CTRL_ACC_EN = 0;
  // reset values
  localparam logic [9:0] DTC_ACC_LOW_RST = 10'h000;
  localparam logic [13:0] DTC_BAL_RST = 14'h0000;
  // cell geometry
  localparam int DTC_CELLS = 14;
  localparam int DTC_RES_W = 14;
  localparam int DTC_TOP_W = 4;
  // scan selection codes
  localparam logic [2:0] DTC_SCAN_COMP_A = 3'h1;
  localparam logic [2:0] DTC_SCAN_COMP_B = 3'h2;
  localparam logic [2:0] DTC_SCAN_SHORT = 3'h4;
  localparam logic [2:0] DTC_SCAN_OPEN = 3'h5;
  localparam logic [2:0] DTC_SCAN_ODD = 3'h6;
  localparam logic [2:0] DTC_SCAN_EVEN = 3'h7;
  // status bit positions
  localparam int DTC_ST_W = 2;
  localparam int DTC_ST_ACC = 0;
  localparam int DTC_ST_BAL = 1;
  // axi responses
  localparam logic [1:0] DTC_RESP_OKAY = 2'h0;
  localparam logic [1:0] DTC_RESP_SLVERR = 2'h2;
endpackage

// File: hdl/dtc_cell_check.sv
// dtc_cell_check: one cell's diagnostic selection and limit compare
// assumes: result is stable while scan_done logic in the parent samples fail
`timescale 1ns/1ns
module dtc_cell_check
  import dtc_pkg::*;
#(
  parameter int IDX = 0,
  parameter int W = DTC_RES_W
) (
  // cell data and settings
  input wire logic [W-1:0] result,
  input wire logic reverse_sense,
  input wire logic measure_enable,
  input wire logic switch_on,
  input wire logic [DTC_TOP_W-1:0] top_index,
  // scan and limits
  input wire logic [2:0] scan_sel,
  input wire logic [W-1:0] short_limit,
  input wire logic [W-1:0] open_low,
  input wire logic [W-1:0] open_high,
  // outcome
  output logic fail
);
  localparam logic [DTC_TOP_W-1:0] CELL_NUM = DTC_TOP_W'(IDX + 1);
  logic checked;
  logic below_uni;
  logic out_bip;

  // limit compares, unipolar and bipolar
  assign below_uni = result < short_limit; // RL9
  assign out_bip = ($signed(result) < $signed(open_low)) || ($signed(result) > $signed(open_high)); // RL13 RL16

  // which cells take part in the selected diagnostic
  always_comb begin
    checked = 1'b0;
    case (scan_sel)
      DTC_SCAN_SHORT: checked = !reverse_sense && measure_enable; // RL8
      DTC_SCAN_OPEN: checked = !reverse_sense && switch_on; // RL11
      DTC_SCAN_ODD: checked = !reverse_sense && (CELL_NUM <= top_index) && CELL_NUM[0]; // RL12
      DTC_SCAN_EVEN: checked = !reverse_sense && (CELL_NUM <= top_index) && !CELL_NUM[0]; // RL12
      default: checked = 1'b0;
    endcase
  end

  // short limit only in short scan, open limits in the other three
  assign fail = checked && ((scan_sel == DTC_SCAN_SHORT) ? below_uni : out_bip); // RL7 RL10
endmodule

// File: hdl/dtc_sticky.sv
// dtc_sticky: sticky event bits with write-one-to-clear, set beats clear
// assumes: set and clr are one-cycle pulses on aclk
`timescale 1ns/1ns
module dtc_sticky #(
  parameter int N = 2
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // events and clears
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] clr,
  // held bits
  output logic [N-1:0] status
);
  // hold until software clears, a same-cycle event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
    end else begin
      status <= (status & ~clr) | set; // RL17
    end
  end
endmodule

// File: hdl/dtc_top.sv
// dtc_top: diagnostic threshold checker with axi4-lite registers
// assumes: scan sequencer pulses scan_done with all results valid in that cycle
// Operation
// RL1 - accuracy low limit is ten bits at 15:6, reset zero, read and write
// RL2 - accuracy check only for comparator scans with the check enable set
// RL3 - during accuracy check route reference through second shift amp and dac
// RL4 - accuracy result below low limit sets the accuracy low alert
// RL5 - a zero low limit never triggers, so the alert is off by default
// RL6 - software programs the low limit near the ideal code
// RL7 - short limit is fourteen bits at 15:2, used in short scan only
// RL8 - short scan checks cells not reversed with measurement enabled
// RL9 - unipolar result below short limit sets the switch alert
// RL10 - open low limit fourteen bits at 15:2, used in open and wire scans
// RL11 - open scan checks cells not reversed with switch on
// RL12 - wire scans check odd or even cells up to highest index, not reversed
// RL13 - bipolar result below open low limit sets the switch alert
// RL14 - software picks a small positive open low limit
// RL15 - host writes each limit before starting its diagnostic
// RL16 - bipolar result above open high limit also sets the switch alert
// RL17 - alert flags stay set until software clears them
`timescale 1ns/1ns
module dtc_top
  import dtc_pkg::*;
#(
  parameter int CELLS = DTC_CELLS,
  parameter int RES_W = DTC_RES_W
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [DTC_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [DTC_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // scan sequencer
  input wire logic [2:0] scan_selection,
  input wire logic scan_done,
  input wire logic accuracy_phase,
  input wire logic [DTC_ACC_W-1:0] accuracy_result,
  // per-cell results and settings
  input wire logic [CELLS*RES_W-1:0] cell_results,
  input wire logic [CELLS-1:0] cell_reverse_sense,
  input wire logic [CELLS-1:0] cell_measure_enable,
  input wire logic [CELLS-1:0] balance_switch_on,
  input wire logic [DTC_TOP_W-1:0] highest_cell_index,
  // analog path steering
  output logic level_shift_amp_two_ref,
  output logic comparator_dac_reference,
  // alerts
  output logic comp_accuracy_low_alert,
  output logic balance_switch_alert,
  output logic irq
);
  // limit and control registers
  logic [DTC_ACC_W-1:0] comp_accuracy_low_limit_field;
  logic [RES_W-1:0] short_limit_field;
  logic [RES_W-1:0] open_low_limit_field;
  logic [RES_W-1:0] open_high_limit_field;
  logic comp_accuracy_check_enable;
  logic [DTC_ST_W-1:0] alert_mask;
  logic [DTC_ST_W-1:0] alert_status;
  logic [CELLS-1:0] fail_cells;
  // bus channel state
  logic aw_full;
  logic w_full;
  logic next_aw_full;
  logic next_w_full;
  logic next_rvalid;
  logic [DTC_IDX_W-1:0] wr_idx;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_go;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  // diagnostic outcome
  logic [CELLS-1:0] cell_fail;
  logic comp_scan;
  logic acc_set;
  logic bal_set;
  logic [DTC_ST_W-1:0] st_set;
  logic [DTC_ST_W-1:0] st_clr;
  // merged write images of the limit registers
  logic [15:0] acc_merge;
  logic [15:0] short_merge;
  logic [15:0] open_low_merge;
  logic [15:0] open_high_merge;

  // merge byte lanes of a 16-bit register image
  function automatic logic [15:0] merge16(input logic [15:0] cur, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] m;
    m = cur;
    if (s[0]) begin
      m[7:0] = d[7:0];
    end
    if (s[1]) begin
      m[15:8] = d[15:8];
    end
    return m;
  endfunction

  // write images with strobed byte lanes merged over the current value
  assign acc_merge = merge16({comp_accuracy_low_limit_field, 6'h00}, wr_data, wr_strb);
  assign short_merge = merge16({short_limit_field, 2'h0}, wr_data, wr_strb);
  assign open_low_merge = merge16({open_low_limit_field, 2'h0}, wr_data, wr_strb);
  assign open_high_merge = merge16({open_high_limit_field, 2'h0}, wr_data, wr_strb);

  // channel occupancy for next cycle
  assign next_aw_full = (aw_full || (awvalid && awready)) && !(bvalid && bready);
  assign next_w_full = (w_full || (wvalid && wready)) && !(bvalid && bready);
  assign next_rvalid = (rvalid && !rready) || (arvalid && arready);
  assign wr_go = aw_full && w_full && !bvalid;

  // write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      wr_idx <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      awready <= !next_aw_full;
      wready <= !next_w_full;
      if (awvalid && awready) begin
        wr_idx <= awaddr[DTC_ADDR_W-1:2];
      end
      if (wvalid && wready) begin
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
    end
  end

  // write decode
  always_comb begin
    case (wr_idx)
      DTC_IDX_ACC_LOW, DTC_IDX_SHORT, DTC_IDX_OPEN_LOW, DTC_IDX_OPEN_HIGH: wr_hit = 1'b1;
      DTC_IDX_CTRL, DTC_IDX_STATUS, DTC_IDX_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write response, slverr on unmapped or read-only index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= DTC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? DTC_RESP_OKAY : DTC_RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // threshold registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comp_accuracy_low_limit_field <= DTC_ACC_LOW_RST; // RL1 RL5
      short_limit_field <= DTC_BAL_RST; // RL7
      open_low_limit_field <= DTC_BAL_RST; // RL10
      open_high_limit_field <= DTC_BAL_RST;
    end else if (wr_go) begin
      case (wr_idx)
        DTC_IDX_ACC_LOW: comp_accuracy_low_limit_field <= acc_merge[15:DTC_ACC_LSB]; // RL1
        DTC_IDX_SHORT: short_limit_field <= short_merge[15:DTC_BAL_LSB]; // RL7
        DTC_IDX_OPEN_LOW: open_low_limit_field <= open_low_merge[15:DTC_BAL_LSB]; // RL10
        DTC_IDX_OPEN_HIGH: open_high_limit_field <= open_high_merge[15:DTC_BAL_LSB]; // RL16
        default: ;
      endcase
    end
  end

  // control and mask registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comp_accuracy_check_enable <= 1'b0;
      alert_mask <= '0;
    end else if (wr_go && wr_strb[0]) begin
      if (wr_idx == DTC_IDX_CTRL) begin
        comp_accuracy_check_enable <= wr_data[DTC_CTRL_ACC_EN];
      end
      if (wr_idx == DTC_IDX_MASK) begin
        alert_mask <= wr_data[DTC_ST_W-1:0];
      end
    end
  end

  // status clears, one written as one clears that bit
  assign st_clr = (wr_go && wr_strb[0] && (wr_idx == DTC_IDX_STATUS)) ? wr_data[DTC_ST_W-1:0] : '0;

  // read decode, reserved bits read zero
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    case (araddr[DTC_ADDR_W-1:2])
      DTC_IDX_ACC_LOW: rd_word[15:DTC_ACC_LSB] = comp_accuracy_low_limit_field; // RL1
      DTC_IDX_SHORT: rd_word[15:DTC_BAL_LSB] = short_limit_field;
      DTC_IDX_OPEN_LOW: rd_word[15:DTC_BAL_LSB] = open_low_limit_field;
      DTC_IDX_OPEN_HIGH: rd_word[15:DTC_BAL_LSB] = open_high_limit_field;
      DTC_IDX_CTRL: rd_word[DTC_CTRL_ACC_EN] = comp_accuracy_check_enable;
      DTC_IDX_STATUS: rd_word[DTC_ST_W-1:0] = alert_status;
      DTC_IDX_MASK: rd_word[DTC_ST_W-1:0] = alert_mask;
      DTC_IDX_FAIL_CELLS: rd_word[CELLS-1:0] = fail_cells;
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel, one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= DTC_RESP_OKAY;
    end else begin
      arready <= !next_rvalid;
      rvalid <= next_rvalid;
      if (arvalid && arready) begin
        rdata <= rd_word;
        rresp <= rd_hit ? DTC_RESP_OKAY : DTC_RESP_SLVERR;
      end
    end
  end

  // per-cell limit checks
  genvar g;
  generate
    for (g = 0; g < CELLS; g++) begin : g_cell
      dtc_cell_check #(
        .IDX(g),
        .W(RES_W)
      ) u_check (
        .result(cell_results[g*RES_W +: RES_W]),
        .reverse_sense(cell_reverse_sense[g]),
        .measure_enable(cell_measure_enable[g]),
        .switch_on(balance_switch_on[g]),
        .top_index(highest_cell_index),
        .scan_sel(scan_selection),
        .short_limit(short_limit_field),
        .open_low(open_low_limit_field),
        .open_high(open_high_limit_field),
        .fail(cell_fail[g])
      );
    end
  endgenerate

  // end-of-scan events
  assign comp_scan = (scan_selection == DTC_SCAN_COMP_A) || (scan_selection == DTC_SCAN_COMP_B);
  assign acc_set = scan_done && comp_scan && comp_accuracy_check_enable && // RL2
    (accuracy_result < comp_accuracy_low_limit_field); // RL4 RL5
  assign bal_set = scan_done && (|cell_fail); // RL9 RL13 RL16
  assign st_set = {bal_set, acc_set};

  // sticky alert bits
  dtc_sticky #(
    .N(DTC_ST_W)
  ) u_sticky (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(st_set),
    .clr(st_clr),
    .status(alert_status)
  );

  // cells that failed the last balancing diagnostic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fail_cells <= '0;
    end else if (scan_done && !comp_scan && scan_selection[2]) begin
      fail_cells <= cell_fail;
    end
  end

  // reference routing while the accuracy check runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_shift_amp_two_ref <= 1'b0;
      comparator_dac_reference <= 1'b0;
    end else begin
      level_shift_amp_two_ref <= accuracy_phase && comp_scan && comp_accuracy_check_enable; // RL3
      comparator_dac_reference <= accuracy_phase && comp_scan && comp_accuracy_check_enable; // RL3
    end
  end

  // alert pins and interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comp_accuracy_low_alert <= 1'b0;
      balance_switch_alert <= 1'b0;
      irq <= 1'b0;
    end else begin
      comp_accuracy_low_alert <= alert_status[DTC_ST_ACC]; // RL17
      balance_switch_alert <= alert_status[DTC_ST_BAL]; // RL17
      irq <= |(alert_status & alert_mask);
    end
  end
endmodule

// File: test/dtc_props.sv
// dtc_props: bus handshake and alert timing checks for dtc_top
// assumes: bound into dtc_top, single aclk domain, sync active-low reset
`timescale 1ns/1ns
module dtc_props
  import dtc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // scan side
  input wire logic [2:0] scan_selection,
  input wire logic scan_done,
  input wire logic accuracy_phase,
  // watched outputs
  input wire logic level_shift_amp_two_ref,
  input wire logic comparator_dac_reference,
  input wire logic comp_accuracy_low_alert,
  input wire logic balance_switch_alert,
  input wire logic irq
);
  // scan qualifiers
  wire comp_sel = scan_selection == DTC_SCAN_COMP_A || scan_selection == DTC_SCAN_COMP_B;
  wire acc_step = accuracy_phase && comp_sel;
  wire acc_done = scan_done && comp_sel;
  wire bal_done = scan_done && scan_selection >= DTC_SCAN_SHORT;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_alert_drop;
    $fell(comp_accuracy_low_alert) || $fell(balance_switch_alert);
  endsequence
  AST_WR_RESP: assert property (s_wr_taken |-> ##2 bvalid) else $error("write not answered");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped early");
  AST_RD_RESP: assert property (arvalid && arready |=> rvalid) else $error("read not answered");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data moved");
  AST_ROUTE_CAUSE: assert property (
    level_shift_amp_two_ref |-> $past(acc_step)) else $error("routing without accuracy step");
  AST_ROUTE_PAIR: assert property (
    level_shift_amp_two_ref == comparator_dac_reference) else $error("amp and dac routing differ");
  AST_ACC_CAUSE: assert property (
    $rose(comp_accuracy_low_alert) |-> $past(acc_done, 2)) else $error("accuracy alert without scan");
  AST_BAL_CAUSE: assert property (
    $rose(balance_switch_alert) |-> $past(bal_done, 2)) else $error("switch alert without scan");
  AST_ALERT_HOLD: assert property (
    s_alert_drop |-> $past(bvalid)) else $error("alert dropped without write");
  AST_IRQ_SRC: assert property (irq |-> comp_accuracy_low_alert || balance_switch_alert)
    else $error("irq without alert");
endmodule
bind dtc_top dtc_props i_dtc_props (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .arvalid, .arready, .rvalid, .rready, .rdata, .scan_selection, .scan_done, .accuracy_phase,
  .level_shift_amp_two_ref, .comparator_dac_reference, .comp_accuracy_low_alert, .balance_switch_alert, .irq);

// File: test/tb_top.sv
// tb_top: random self-checking bench for dtc_top against an integer model
// assumes: dtc_pkg and design compiled first, checker bound from its own file
`timescale 1ns/1ns
module tb_top;
  import dtc_pkg::*;
  // stimulus and observed signals
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic scan_done = 0, accuracy_phase = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d;
  logic [2:0] scan_selection = 0, s;
  logic [9:0] accuracy_result = 0, ar;
  logic [195:0] cell_results = 0, cr;
  logic [13:0] cell_reverse_sense = 0, cell_measure_enable = 0, balance_switch_on = 0, rv, me, so, c, fv;
  logic [3:0] highest_cell_index = 0, wstrb = 4'hf;
  logic [31:0] v[6];
  logic q;
  wire logic awready, wready, bvalid, arready, rvalid, irq, level_shift_amp_two_ref, comparator_dac_reference;
  wire logic comp_accuracy_low_alert, balance_switch_alert;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int err_total = 0, checks = 0, seed = 83655;
  int st, fc, al, b, g, t, k, sv, top;
  localparam logic [11:0] A[6] = '{12'h108, 12'h10c, 12'h110, 12'h114, 12'h180, 12'h188};
  localparam logic [31:0] M[6] = '{32'hffc0, 32'hfffc, 32'hfffc, 32'hfffc, 32'h1, 32'h3};
  // 50 ns clock
  always #25 aclk = ~aclk;
  dtc_top i_dtc_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .scan_selection,
    .scan_done, .accuracy_phase, .accuracy_result, .cell_results, .cell_reverse_sense, .cell_measure_enable,
    .balance_switch_on, .highest_cell_index, .level_shift_amp_two_ref, .comparator_dac_reference,
    .comp_accuracy_low_alert, .balance_switch_alert, .irq);
  // closing report
  task automatic print_verdict();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // compare and count
  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // bounded wait ran out
  task automatic lim(input int i);
    if (i >= 40) begin
      err_total++;
      print_verdict();
    end
  endtask
  // one axi4-lite write, address and data offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] x, input logic [1:0] e);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    lim(i);
    cmp(32'(bresp), 32'(e));
    bready <= 0;
  endtask
  // one axi4-lite read with expected data and response
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    lim(i);
    cmp(rdata, e);
    cmp(32'(rresp), 32'(er));
    rready <= 0;
  endtask
  // main sequence: two reset passes of random scans
  initial begin
    for (k = 0; k < 2; k++) begin
      aresetn <= 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      st = 0;
      fc = 0;
      for (g = 0; g < 6; g++) rd(A[g], 0, 0);
      rd(12'h184, 0, 0);
      rd(12'h18c, 0, 0);
      wr(12'h200, 32'h5, DTC_RESP_SLVERR);
      wr(12'h18c, 32'h5, DTC_RESP_SLVERR);
      rd(12'h200, 0, DTC_RESP_SLVERR);
      // only the strobed byte lane lands, ctrl needs lane zero
      wstrb <= 4'h2;
      wr(A[1], 32'hffff, 0);
      wr(A[4], 32'h1, 0);
      wstrb <= 4'hf;
      rd(A[1], 32'hff00, 0);
      rd(A[4], 0, 0);
      for (t = 0; t < 40; t++) begin
        b = $random(seed) & 'hff;
        for (g = 0; g < 6; g++) v[g] = $random(seed);
        if (v[0][1:0] == 0) v[0][15:6] = 0;
        if (v[0][1:0] == 1) v[0][15:6] = 10'h1d8;
        v[1][15:2] = 14'(b);
        v[2][15:2] = 14'(b);
        v[3][15:2] = 14'(b + 64);
        v[4][0] = |v[4][1:0];
        al = v[0][15:6];
        for (g = 0; g < 6; g++) wr(A[g], v[g], 0);
        for (g = 0; g < 6; g++) rd(A[g], v[g] & M[g], 0);
        d = $random(seed);
        wr(12'h184, {30'h0, d[1:0]}, 0);
        st = st & ~int'(d[1:0]);
        // scan inputs and model outcome
        s = 3'(t);
        rv = 14'($random(seed));
        me = 14'($random(seed));
        so = 14'($random(seed));
        top = 1 + {$random(seed)} % 14;
        ar = 10'(al - 1 + {$random(seed)} % 2);
        fv = 0;
        for (g = 0; g < 14; g++) begin
          d = $random(seed);
          case (d[3:0])
            0: c = d[17:4];
            1: c = 14'(b);
            2: c = 14'(b + 64);
            default: c = 14'(b + 1 + d[9:4]);
          endcase
          cr[g*14 +: 14] = c;
          sv = $signed(c);
          q = s == 4 ? me[g] : s == 5 ? so[g] : (g + 1 <= top && (g + 1) % 2 == (s == 6));
          if (s >= 4 && !rv[g] && q && (s == 4 ? int'(c) < b : (sv < b || sv > b + 64))) fv[g] = 1;
        end
        if (s >= 4) fc = fv;
        if (s >= 4 && fv != 0) st = st | 2;
        q = (s == 1 || s == 2) && v[4][0];
        if (q && ar < al) st = st | 1;
        @(posedge aclk);
        scan_selection <= s;
        cell_results <= cr;
        cell_reverse_sense <= rv;
        cell_measure_enable <= me;
        balance_switch_on <= so;
        highest_cell_index <= 4'(top);
        accuracy_result <= ar;
        accuracy_phase <= 1;
        scan_done <= 1;
        @(posedge aclk);
        scan_done <= 0;
        accuracy_phase <= 0;
        #1;
        cmp(32'(level_shift_amp_two_ref), 32'(q));
        cmp(32'(comparator_dac_reference), 32'(q));
        rd(12'h184, st, 0);
        rd(12'h18c, fc, 0);
        cmp(32'(comp_accuracy_low_alert), 32'(st & 1));
        cmp(32'(balance_switch_alert), 32'(st >> 1 & 1));
        cmp(32'(irq), 32'((st & v[5] & 3) != 0));
      end
    end
    print_verdict();
  end
endmodule
